// ===== rtl/tgc_pkg.sv
// tgc_pkg: constants for the timer gate control block
// assumes a single 200 MHz clock domain and an 8-bit register port
//
// Summary of operation
// - polarity one counts while gate high; zero counts while gate low
// - toggle mode flips a gate flip-flop on each active gate edge (after polarity) while the timer is on; timer off clears it
// - clearing toggle mode disables toggling and clears the flip-flop
// - single-pulse mode takes over the gate; otherwise normal path applies
// - live gate value shows the gate regardless of gate enable
// - source select: 00 gate pin, 01 8-bit overflow, 10 comparator out
package tgc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [1:0] TGC_ADDR_CTRL = 2'h0;
  localparam logic [1:0] TGC_ADDR_IRQ_STATUS = 2'h1;
  localparam logic [1:0] TGC_ADDR_IRQ_MASK = 2'h2;
  localparam logic [7:0] TGC_CTRL_RESET = 8'h00;
  localparam logic [7:0] TGC_CTRL_WMASK = 8'hFB;
  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int TGC_BIT_ENABLE = 7;
  localparam int TGC_BIT_POL = 6;
  localparam int TGC_BIT_TOGGLE = 5;
  localparam int TGC_BIT_SPM = 4;
  localparam int TGC_BIT_GO = 3;
  localparam int TGC_BIT_LIVE = 2;
  localparam int TGC_BIT_SRC_HI = 1;
  localparam int TGC_BIT_SRC_LO = 0;
  // ----------------------------------------------------------------
  // gate sources and interrupt bits
  // ----------------------------------------------------------------
  localparam logic [1:0] TGC_SRC_PIN = 2'h0;
  localparam logic [1:0] TGC_SRC_TMR8 = 2'h1;
  localparam logic [1:0] TGC_SRC_CMP = 2'h2;
  localparam int TGC_IRQ_DONE = 0;
  localparam int TGC_IRQ_EDGE = 1;
  localparam logic [1:0] TGC_IRQ_ZERO = 2'h0;
  typedef enum logic [1:0] {TGC_SP_IDLE, TGC_SP_WAIT, TGC_SP_RUN} tgc_sp_state_t;
endpackage

// ===== rtl/tgc_sync_if.sv
// tgc_sync_if: carries raw gate inputs and their synchronised copies
// assumes one clock; the synchroniser is the only driver of the synced side
`timescale 1ns/1ps
interface tgc_sync_if;
  logic [2:0] raw;
  logic [2:0] synced;
  modport src (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

// ===== rtl/tgc_sync.sv
// tgc_sync: two-flop synchroniser for the three gate inputs
// assumes inputs are asynchronous to mclk
`timescale 1ns/1ps
module tgc_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  tgc_sync_if.sync bus
);
  logic [2:0] meta;
  logic [2:0] stage;
  // meta is read only by stage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= 3'h0;
      stage <= 3'h0;
    end else if (clkEn) begin
      meta <= bus.raw;
      stage <= meta;
    end
  end
  assign bus.synced = stage;
endmodule

// ===== rtl/timer_gate_control.sv
// timer_gate_control: gate selection, polarity, toggle and single pulse
// assumes a synchronous register port on mclk; gate inputs may be async
`timescale 1ns/1ps
module timer_gate_control (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic timerOn,
  input wire logic gatePin,
  input wire logic tmr8Overflow,
  input wire logic firstComparatorSyncedOut,
  output logic countEnable,
  output logic gateLiveValue,
  output logic irq
);
  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  tgc_sync_if syncBus ();
  assign syncBus.raw = {firstComparatorSyncedOut, tmr8Overflow, gatePin};
  tgc_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .clkEn(clkEn),
    .bus(syncBus.sync)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic gateEnable;
  logic gatePolarity;
  logic gateToggleMode;
  logic gateSinglePulseMode;
  logic singlePulseGoStatus;
  logic [1:0] gateSourceSelect;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic toggleFf;
  logic selPrev;
  tgc_pkg::tgc_sp_state_t spState;
  tgc_pkg::tgc_sp_state_t next_spState;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wrCtrl = regWrite && (regAddr == tgc_pkg::TGC_ADDR_CTRL);
  wire wrStatus = regWrite && (regAddr == tgc_pkg::TGC_ADDR_IRQ_STATUS);
  wire wrMask = regWrite && (regAddr == tgc_pkg::TGC_ADDR_IRQ_MASK);
  wire [7:0] ctrlIn = regWrData & tgc_pkg::TGC_CTRL_WMASK;

  // source selection; code 11 falls back to the pin
  logic selGate;
  always_comb begin
    case (gateSourceSelect)
      tgc_pkg::TGC_SRC_TMR8: selGate = syncBus.synced[1];
      tgc_pkg::TGC_SRC_CMP: selGate = syncBus.synced[2];
      default: selGate = syncBus.synced[0];
    endcase
  end

  // one polarity helper for the live gate and for the edge detector, so a
  // polarity write alone never looks like a gate edge
  function automatic logic tgcApplyPol(input logic sig, input logic pol);
    tgcApplyPol = pol ? sig : ~sig;
  endfunction

  // polarity folded in first so toggle and single pulse see active edges
  wire polGate = tgcApplyPol(selGate, gatePolarity);
  // selPrev holds the raw selected gate; it resets to the synchroniser's
  // reset level so no false edge follows reset
  wire prevPolGate = tgcApplyPol(selPrev, gatePolarity);
  wire riseEdge = polGate && !prevPolGate;
  wire toggledGate = gateToggleMode ? toggleFf : polGate;
  wire spGate = (spState == tgc_pkg::TGC_SP_RUN) && toggledGate;
  wire effGate = gateSinglePulseMode ? spGate : toggledGate;
  // count permission; gate enable has no effect with timer off
  wire next_count = timerOn && (!gateEnable || effGate);
  wire spDone = (spState == tgc_pkg::TGC_SP_RUN) && !toggledGate;
  wire spStart = (spState == tgc_pkg::TGC_SP_WAIT) && toggledGate;

  // ----------------------------------------------------------------
  // single pulse sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_spState = spState;
    case (spState)
      tgc_pkg::TGC_SP_IDLE: begin
        if (singlePulseGoStatus && gateSinglePulseMode) begin
          next_spState = tgc_pkg::TGC_SP_WAIT;
        end
      end
      tgc_pkg::TGC_SP_WAIT: begin
        if (!singlePulseGoStatus || !gateSinglePulseMode) begin
          next_spState = tgc_pkg::TGC_SP_IDLE;
        end else if (spStart) begin
          next_spState = tgc_pkg::TGC_SP_RUN;
        end
      end
      tgc_pkg::TGC_SP_RUN: begin
        if (spDone || !gateSinglePulseMode) begin
          next_spState = tgc_pkg::TGC_SP_IDLE;
        end
      end
      default: next_spState = tgc_pkg::TGC_SP_IDLE;
    endcase
  end

  // acquisition end only counts when a pulse actually ran
  wire doneEvent = spDone && gateSinglePulseMode;
  wire [1:0] irqSet = {riseEdge, doneEvent};

  // write-one clear first, then set, so an event in the clearing cycle
  // survives; shared by the status flops and the interrupt output
  function automatic logic [1:0] tgcStatusNext(input logic [1:0] cur, input logic clr,
      input logic [1:0] ones, input logic [1:0] evt);
    tgcStatusNext = (cur & ~(clr ? ones : tgc_pkg::TGC_IRQ_ZERO)) | evt;
  endfunction
  wire [1:0] next_irqStatus = tgcStatusNext(irqStatus, wrStatus, regWrData[1:0], irqSet);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // hardware clear of go beats a software write in the same cycle so
  // a finished acquisition is never re-armed by a stale write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gateEnable <= tgc_pkg::TGC_CTRL_RESET[tgc_pkg::TGC_BIT_ENABLE];
      gatePolarity <= tgc_pkg::TGC_CTRL_RESET[tgc_pkg::TGC_BIT_POL];
      gateToggleMode <= tgc_pkg::TGC_CTRL_RESET[tgc_pkg::TGC_BIT_TOGGLE];
      gateSinglePulseMode <= tgc_pkg::TGC_CTRL_RESET[tgc_pkg::TGC_BIT_SPM];
      singlePulseGoStatus <= tgc_pkg::TGC_CTRL_RESET[tgc_pkg::TGC_BIT_GO];
      gateSourceSelect <=
        tgc_pkg::TGC_CTRL_RESET[tgc_pkg::TGC_BIT_SRC_HI:tgc_pkg::TGC_BIT_SRC_LO];
    end else if (clkEn) begin
      if (wrCtrl) begin
        gateEnable <= ctrlIn[tgc_pkg::TGC_BIT_ENABLE];
        gatePolarity <= ctrlIn[tgc_pkg::TGC_BIT_POL];
        gateToggleMode <= ctrlIn[tgc_pkg::TGC_BIT_TOGGLE];
        gateSinglePulseMode <= ctrlIn[tgc_pkg::TGC_BIT_SPM];
        gateSourceSelect <= ctrlIn[tgc_pkg::TGC_BIT_SRC_HI:tgc_pkg::TGC_BIT_SRC_LO];
      end
      if (doneEvent) begin
        singlePulseGoStatus <= 1'b0;
      end else if (wrCtrl) begin
        singlePulseGoStatus <= ctrlIn[tgc_pkg::TGC_BIT_GO];
      end
    end
  end

  // ----------------------------------------------------------------
  // gate flip-flops and sequencer state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      toggleFf <= 1'b0;
      selPrev <= 1'b0;
      spState <= tgc_pkg::TGC_SP_IDLE;
    end else if (clkEn) begin
      selPrev <= selGate;
      spState <= next_spState;
      if (!gateToggleMode || !timerOn) begin
        toggleFf <= 1'b0;
      end else if (riseEdge) begin
        toggleFf <= ~toggleFf;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqStatus <= tgc_pkg::TGC_IRQ_ZERO;
      irqMask <= tgc_pkg::TGC_IRQ_ZERO;
    end else if (clkEn) begin
      irqStatus <= next_irqStatus;
      if (wrMask) begin
        irqMask <= regWrData[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux and registered outputs
  // ----------------------------------------------------------------
  logic [7:0] rdMux;
  always_comb begin
    case (regAddr)
      tgc_pkg::TGC_ADDR_CTRL: rdMux = {gateEnable, gatePolarity, gateToggleMode,
        gateSinglePulseMode, singlePulseGoStatus, effGate, gateSourceSelect};
      tgc_pkg::TGC_ADDR_IRQ_STATUS: rdMux = {6'h00, irqStatus};
      tgc_pkg::TGC_ADDR_IRQ_MASK: rdMux = {6'h00, irqMask};
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
      countEnable <= 1'b0;
      gateLiveValue <= 1'b0;
      irq <= 1'b0;
    end else if (clkEn) begin
      regRdData <= regRead ? rdMux : 8'h00;
      countEnable <= next_count;
      gateLiveValue <= effGate;
      irq <= |(next_irqStatus & irqMask);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seqArmed;
    spState == tgc_pkg::TGC_SP_WAIT;
  endsequence
  sequence seqRunEnds;
    (spState == tgc_pkg::TGC_SP_RUN) && !toggledGate && gateSinglePulseMode;
  endsequence

  AST_POLARITY: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && !gateToggleMode && !gateSinglePulseMode && gateEnable && timerOn)
    |=> (!clkEn || countEnable == $past(gatePolarity ? selGate : ~selGate)))
    else $error("count does not follow gate polarity");
  AST_TOGGLE_FLIP: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && gateToggleMode && timerOn && riseEdge) |=> (toggleFf != $past(toggleFf)))
    else $error("toggle flip-flop missed a rising edge");
  AST_TOGGLE_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && !gateToggleMode) |=> !toggleFf)
    else $error("toggle flip-flop not cleared");
  AST_SP_OWNS: assert property (@(posedge mclk) disable iff (rst)
    (gateSinglePulseMode && spState != tgc_pkg::TGC_SP_RUN) |-> !effGate)
    else $error("gate open outside single pulse");
  AST_GO_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    (clkEn and seqRunEnds) |=> !singlePulseGoStatus)
    else $error("go status not cleared at acquisition end");
  AST_ARM_WAIT: assert property (@(posedge mclk) disable iff (rst)
    seqArmed |-> singlePulseGoStatus || $past(singlePulseGoStatus))
    else $error("waiting without go status");
  AST_LIVE: assert property (@(posedge mclk) disable iff (rst)
    clkEn |=> (!clkEn || gateLiveValue == $past(effGate)))
    else $error("live gate value stale");
  AST_OFF: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && !timerOn) |=> (!clkEn || !countEnable))
    else $error("counting while timer off");
  AST_NOGATE: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && timerOn && !gateEnable) |=> (!clkEn || countEnable))
    else $error("gate blocks count with enable clear");
  AST_SOURCE: assert property (@(posedge mclk) disable iff (rst)
    (gateSourceSelect == tgc_pkg::TGC_SRC_TMR8) |-> (selGate == syncBus.synced[1]))
    else $error("wrong gate source");

  // the acquisition walk, step by step: armed, gate opens, pulse runs
  sequence seqGateOpens;
    clkEn && spStart && singlePulseGoStatus && gateSinglePulseMode;
  endsequence
  sequence seqRunning;
    spState == tgc_pkg::TGC_SP_RUN;
  endsequence

  AST_SP_START: assert property (@(posedge mclk) disable iff (rst)
    (seqArmed ##0 seqGateOpens) |=> seqRunning)
    else $error("armed acquisition missed the opening gate");
  AST_SP_COUNTS: assert property (@(posedge mclk) disable iff (rst)
    (seqRunning ##0 (clkEn && toggledGate && gateSinglePulseMode && gateEnable && timerOn))
    |=> countEnable)
    else $error("no count during the acquired pulse");
  AST_SP_IDLE_SHUT: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && gateSinglePulseMode && gateEnable && spState == tgc_pkg::TGC_SP_IDLE)
    |=> !countEnable)
    else $error("count outside an acquisition");
  AST_GO_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (seqArmed ##0 (clkEn && singlePulseGoStatus && !wrCtrl)) |=> singlePulseGoStatus)
    else $error("go status dropped while waiting");
  AST_TOGGLE_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && gateToggleMode && timerOn && !riseEdge) |=> (toggleFf == $past(toggleFf)))
    else $error("toggle flip-flop moved without a rising edge");
  // live value against the synchronised input itself, not the select mux
  AST_PIN_GATE: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && gateSourceSelect == tgc_pkg::TGC_SRC_PIN && !gateToggleMode
      && !gateSinglePulseMode)
    |=> (gateLiveValue == ($past(gatePolarity) ~^ $past(syncBus.synced[0]))))
    else $error("pin source not followed");
  AST_CMP_GATE: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && gateSourceSelect == tgc_pkg::TGC_SRC_CMP && !gateToggleMode
      && !gateSinglePulseMode)
    |=> (gateLiveValue == ($past(gatePolarity) ~^ $past(syncBus.synced[2]))))
    else $error("comparator source not followed");
  // status bits are sticky: only a write of one clears them
  AST_STATUS_STICKY: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && !wrStatus) |=> ((irqStatus & $past(irqStatus)) == $past(irqStatus)))
    else $error("status bit lost without a clear");
  AST_DONE_SETS: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && doneEvent) |=> irqStatus[tgc_pkg::TGC_IRQ_DONE])
    else $error("acquisition end not flagged");
  AST_EDGE_SETS: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && riseEdge) |=> irqStatus[tgc_pkg::TGC_IRQ_EDGE])
    else $error("gate edge not flagged");
  // interrupt follows status and mask, except right after a mask write
  AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (rst)
    (clkEn && !wrMask) |=> (irq == |(irqStatus & irqMask)))
    else $error("interrupt does not follow status and mask");
endmodule

// ===== test/testbench.sv
// testbench: register-level checks of the timer gate control block
// assumes the block's register port, a single 200 MHz clock and clkEn high except during the freeze check
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdData;
  logic timerOn = 1'b1;
  logic gatePin = 1'b0;
  logic tmr8Overflow = 1'b0;
  logic firstComparatorSyncedOut = 1'b0;
  logic countEnable;
  logic gateLiveValue;
  logic irq;
  logic [7:0] v;
  int bad_count = 0;
  int checks_done = 0;
  // ----------------------------------------------------------------
  // clock, design and shared tasks
  // ----------------------------------------------------------------
  initial forever #2.5 mclk = ~mclk;
  timer_gate_control dut_u (.mclk(mclk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .timerOn(timerOn), .gatePin(gatePin), .tmr8Overflow(tmr8Overflow),
    .firstComparatorSyncedOut(firstComparatorSyncedOut), .countEnable(countEnable),
    .gateLiveValue(gateLiveValue), .irq(irq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // leading edge keeps two strobes of back-to-back calls in separate time steps
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask
  // drive the chosen source to val and the other two to its inverse
  task automatic setSrc(input logic [1:0] s, input logic val);
    @(posedge mclk);
    gatePin <= (s == tgc_pkg::TGC_SRC_PIN) ? val : !val;
    tmr8Overflow <= (s == tgc_pkg::TGC_SRC_TMR8) ? val : !val;
    firstComparatorSyncedOut <= (s == tgc_pkg::TGC_SRC_CMP) ? val : !val;
  endtask
  // two synchroniser stages plus the output register, with margin
  task automatic settle;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
  initial begin
    logic [1:0] s;
    logic p;
    logic g;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1 chk({6'h0, countEnable, irq}, 8'h00, "outputs after reset");
    // inputs low with active-low polarity: the live bit reads as an open gate
    rd(tgc_pkg::TGC_ADDR_CTRL); chk(v, tgc_pkg::TGC_CTRL_RESET | 8'h04, "ctrl reset");
    rd(tgc_pkg::TGC_ADDR_IRQ_STATUS); chk(v, 8'h00, "status reset");
    rd(tgc_pkg::TGC_ADDR_IRQ_MASK); chk(v, 8'h00, "mask reset");
    wr(2'h3, 8'hFF);
    rd(2'h3); chk(v, 8'h00, "unmapped read");
    rd(tgc_pkg::TGC_ADDR_CTRL); chk(v, 8'h04, "ctrl after unmapped write");
    // every source and polarity with gating on and the timer running
    for (int i = 0; i < 12; i++) begin
      s = 2'(i % 3);
      p = 1'((i / 3) % 2);
      g = 1'(i / 6);
      wr(tgc_pkg::TGC_ADDR_CTRL, 8'h80 | {1'b0, p, 4'h0, s});
      setSrc(s, g);
      settle(); chk({7'h0, countEnable}, {7'h0, g == p}, "gated count");
    end
    // the unused source code falls back to the pin; the others are driven opposite
    wr(tgc_pkg::TGC_ADDR_CTRL, 8'hC3);
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b1);
    settle(); chk({7'h0, countEnable}, 8'h01, "code 11 pin high");
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b0);
    settle(); chk({7'h0, countEnable}, 8'h00, "code 11 pin low");
    // timer off wins over the gate, gate enable clear ignores it
    wr(tgc_pkg::TGC_ADDR_CTRL, 8'hC0);
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b1);
    settle(); chk({7'h0, countEnable}, 8'h01, "gate active");
    @(posedge mclk);
    timerOn <= 1'b0;
    settle(); chk({7'h0, countEnable}, 8'h00, "timer off");
    @(posedge mclk);
    timerOn <= 1'b1;
    wr(tgc_pkg::TGC_ADDR_CTRL, 8'h40);
    settle(); chk({7'h0, gateLiveValue}, 8'h01, "live gate high");
    rd(tgc_pkg::TGC_ADDR_CTRL); chk(v, 8'h44, "live bit in ctrl");
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b0);
    settle(); chk({7'h0, countEnable}, 8'h01, "ungated count");
    chk({7'h0, gateLiveValue}, 8'h00, "live gate low");
    // clock enable low freezes synchroniser and outputs alike
    @(posedge mclk);
    clkEn <= 1'b0;
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b1);
    settle(); chk({7'h0, gateLiveValue}, 8'h00, "frozen live gate");
    @(posedge mclk);
    clkEn <= 1'b1;
    settle(); chk({7'h0, gateLiveValue}, 8'h01, "thawed live gate");
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b0);
    // toggle mode: the flip-flop flips on rising edges only
    wr(tgc_pkg::TGC_ADDR_CTRL, 8'hE0);
    settle(); chk({7'h0, countEnable}, 8'h00, "toggle start");
    for (int i = 0; i < 4; i++) begin
      setSrc(tgc_pkg::TGC_SRC_PIN, !i[0]);
      settle(); chk({7'h0, countEnable}, {7'h0, i < 2}, "toggle step");
    end
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b1);
    settle(); chk({7'h0, countEnable}, 8'h01, "toggle set");
    wr(tgc_pkg::TGC_ADDR_CTRL, 8'hC0);
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b0);
    wr(tgc_pkg::TGC_ADDR_CTRL, 8'hE0);
    settle(); chk({7'h0, countEnable}, 8'h00, "toggle cleared");
    // single pulse acquisition with the done interrupt unmasked
    wr(tgc_pkg::TGC_ADDR_IRQ_STATUS, 8'hFF);
    wr(tgc_pkg::TGC_ADDR_IRQ_MASK, 8'h01);
    wr(tgc_pkg::TGC_ADDR_CTRL, 8'hD8);
    settle(); chk({7'h0, countEnable}, 8'h00, "armed waiting");
    rd(tgc_pkg::TGC_ADDR_CTRL); chk(v & 8'h08, 8'h08, "go armed");
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b1);
    settle(); chk({7'h0, countEnable}, 8'h01, "pulse running");
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b0);
    settle(); chk({7'h0, countEnable}, 8'h00, "pulse ended");
    rd(tgc_pkg::TGC_ADDR_CTRL); chk(v & 8'h08, 8'h00, "go done");
    chk({7'h0, irq}, 8'h01, "done irq");
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b1);
    settle(); chk({7'h0, countEnable}, 8'h00, "no second pulse");
    setSrc(tgc_pkg::TGC_SRC_PIN, 1'b0);
    rd(tgc_pkg::TGC_ADDR_IRQ_STATUS); chk(v, 8'h03, "status sticky");
    wr(tgc_pkg::TGC_ADDR_IRQ_MASK, 8'h00);
    settle(); chk({7'h0, irq}, 8'h00, "irq masked");
    wr(tgc_pkg::TGC_ADDR_IRQ_STATUS, 8'h03);
    rd(tgc_pkg::TGC_ADDR_IRQ_STATUS); chk(v, 8'h00, "status cleared");
    conclude();
  end
endmodule
